// *** adc_flag_pkg.sv ***
package adc_flag_pkg;
   localparam int          NUM_CH        = 8;
   localparam int          DATA_W        = 10;
   localparam int          CONV_CYCLES   = 20;
   // byte addresses of the register map
   localparam logic [11:0] OFF_CTRL      = 12'h000;
   localparam logic [11:0] OFF_MODE      = 12'h004;
   localparam logic [11:0] OFF_CH_EN     = 12'h010;
   localparam logic [11:0] OFF_CH_DIS    = 12'h014;
   localparam logic [11:0] OFF_CH_STAT   = 12'h018;
   localparam logic [11:0] OFF_STATUS    = 12'h01C;
   localparam logic [11:0] OFF_LAST_DATA = 12'h020;
   localparam logic [11:0] OFF_CH_DATA0  = 12'h030;
   // field positions
   localparam int          CTRL_START_BIT = 1;
   localparam int          MODE_SLEEP_BIT = 5;
   localparam int          ST_OVR_LSB     = 8;
   localparam int          ST_DATA_READY_FLAG_BIT    = 16;
   localparam int          ST_GOVR_BIT    = 17;
   localparam int          ST_SLEEP_BIT   = 18;
   localparam int          ST_BUSY_BIT    = 19;
   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
endpackage

// *** adc_status_flag_logic.sv ***
// Register access over APB and the register addresses are this design's own decisions.
module adc_status_flag_logic
   import adc_flag_pkg::*;
(
   input  wire logic                             clk,
   input  wire logic                             reset_n,
   input  wire logic [11:0]                      paddr,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic [adc_flag_pkg::DATA_W-1:0]  convResult,
   output logic                                  sleepActive
);
   import adc_flag_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0]             chEn;
      logic                          sleepReq;
      logic                          sleepOn;
      logic                          busy;
      logic [4:0]                    convCnt;
      logic [2:0]                    curCh;
      logic [2:0]                    lastCh;
      logic [NUM_CH-1:0]             eoc;
      logic [NUM_CH-1:0]             ovr;
      logic                          data_ready_flag;
      logic                          govr;
      logic [NUM_CH*DATA_W-1:0]      chData;
      logic [DATA_W-1:0]             lastData;
      logic [31:0]                   rdata;
      logic                          ready;
      logic                          err;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // next channel to convert after cur, wrapping over enabled set
   function automatic logic [2:0] nextCh(input logic [NUM_CH-1:0] en,
                                         input logic [2:0] cur);
      logic [2:0] res;
      logic [2:0] idx;
      res = cur;
      for (int k = NUM_CH; k >= 1; k--) begin
         idx = 3'(int'(cur) + k);
         if (en[idx]) begin
            res = idx;
         end
      end
      return res;
   endfunction

   // byte address of one channel data register
   function automatic logic [11:0] chAddr(input int n);
      return 12'(int'(OFF_CH_DATA0) + 4 * n);
   endfunction

   logic access;
   logic wrAcc;
   logic rdAcc;
   logic convEnd;
   logic endStores;
   logic rdLast;
   logic rdStat;
   logic chRdHit;
   logic [NUM_CH-1:0] rdCh;
   logic [NUM_CH-1:0] disMask;
   logic [31:0]       rdMux;

   // ----------------------------------------------------------------------
   // decode and next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt  = st_r;
      // access phase answered one cycle later, so every access phase is 2 cycles
      access  = psel && penable && !st_r.ready;
      wrAcc   = access && pwrite;
      rdAcc   = access && !pwrite;
      convEnd = st_r.busy && (st_r.convCnt == 5'(CONV_CYCLES - 1));
      // a channel disabled in the end cycle still stores, as the
      // conversion was launched under the old enable
      endStores = convEnd && st_r.chEn[st_r.curCh];
      rdLast  = rdAcc && (paddr == OFF_LAST_DATA);
      rdStat  = rdAcc && (paddr == OFF_STATUS);
      rdCh    = '0;
      chRdHit = 1'b0;
      for (int n = 0; n < NUM_CH; n++) begin
         rdCh[n] = rdAcc && (paddr == chAddr(n));
         chRdHit = chRdHit || rdCh[n];
      end
      disMask = (wrAcc && paddr == OFF_CH_DIS) ? pwdata[NUM_CH-1:0] : '0;

      // read data mux
      rdMux = ZERO_WORD;
      case (paddr)
         OFF_MODE:      rdMux[MODE_SLEEP_BIT] = st_r.sleepReq;
         OFF_CH_STAT:   rdMux[NUM_CH-1:0] = st_r.chEn;
         OFF_STATUS: begin
            rdMux[NUM_CH-1:0]                 = st_r.eoc;
            rdMux[ST_OVR_LSB+:NUM_CH]         = st_r.ovr;
            rdMux[ST_DATA_READY_FLAG_BIT]                = st_r.data_ready_flag;
            rdMux[ST_GOVR_BIT]                = st_r.govr;
            rdMux[ST_SLEEP_BIT]               = st_r.sleepOn;
            rdMux[ST_BUSY_BIT]                = st_r.busy;
         end
         OFF_LAST_DATA: rdMux[DATA_W-1:0] = st_r.lastData;
         default: begin
            for (int n = 0; n < NUM_CH; n++) begin
               if (paddr == chAddr(n)) begin
                  rdMux[DATA_W-1:0] = st_r.chData[n*DATA_W +: DATA_W];
               end
            end
         end
      endcase

      // bus answer: pulse ready, flag misaligned addresses and those past the last channel data register
      st_nxt.ready = psel && penable && !st_r.ready;
      st_nxt.rdata = rdAcc ? rdMux : ZERO_WORD;
      st_nxt.err   = access && (paddr > chAddr(NUM_CH - 1) || paddr[1:0] != 2'b00);

      // channel enable and mode writes
      if (wrAcc && paddr == OFF_CH_EN) begin
         st_nxt.chEn = st_r.chEn | pwdata[NUM_CH-1:0];
      end
      st_nxt.chEn = st_nxt.chEn & ~disMask;
      if (wrAcc && paddr == OFF_MODE) begin
         st_nxt.sleepReq = pwdata[MODE_SLEEP_BIT];
         if (!pwdata[MODE_SLEEP_BIT]) begin
            st_nxt.sleepOn = 1'b0;
         end
      end

      // conversion sequencer
      if (st_r.busy) begin
         st_nxt.convCnt = st_r.convCnt + 5'd1;
      end
      if (convEnd) begin
         st_nxt.convCnt = 5'd0;
         if (nextCh(st_r.chEn & ~disMask, st_r.curCh) > st_r.curCh &&
             (st_r.chEn & ~disMask) != '0) begin
            st_nxt.curCh = nextCh(st_r.chEn & ~disMask, st_r.curCh);
         end else begin
            st_nxt.busy = 1'b0;
            // sleep is entered only at a conversion end, never when idle;
            // the next value keeps a same-cycle wake write from being lost
            st_nxt.sleepOn = st_nxt.sleepReq;
         end
      end
      if (wrAcc && paddr == OFF_CTRL && pwdata[CTRL_START_BIT] &&
          !st_r.busy && st_r.chEn != '0) begin
         st_nxt.busy    = 1'b1;
         st_nxt.convCnt = 5'd0;
         st_nxt.curCh   = nextCh(st_r.chEn, 3'(NUM_CH - 1));
      end

      // end-of-conversion and channel overrun: reads clear first, end sets
      for (int n = 0; n < NUM_CH; n++) begin
         if (rdCh[n]) begin
            st_nxt.eoc[n] = 1'b0;
         end
         if (rdStat) begin
            st_nxt.ovr[n] = 1'b0;
         end
      end
      // the last-data word belongs to the channel stored last, which
      // differs from the channel now converting once the scan moves on
      if (rdLast) begin
         st_nxt.eoc[st_r.lastCh] = 1'b0;
      end
      if (endStores) begin
         st_nxt.lastCh = st_r.curCh;
         st_nxt.chData[st_r.curCh*DATA_W +: DATA_W] = convResult;
         st_nxt.lastData = convResult;
         st_nxt.eoc[st_r.curCh] = 1'b1;
         if (st_r.eoc[st_r.curCh]) begin
            st_nxt.ovr[st_r.curCh] = 1'b1;
         end
      end

      // data ready: only the last-data read clears it, any store sets it
      if (rdLast) begin
         st_nxt.data_ready_flag = 1'b0;
      end
      if (endStores) begin
         st_nxt.data_ready_flag = 1'b1;
      end

      // general overrun: status read clears, new overrun set wins
      if (rdStat) begin
         st_nxt.govr = 1'b0;
      end
      if (endStores && st_r.data_ready_flag) begin
         st_nxt.govr = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   // single domain; all flags drop together under reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata      = st_r.rdata;
   assign pready      = st_r.ready;
   assign pslverr     = st_r.err;
   assign sleepActive = st_r.sleepOn;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence storeEvt;
      endStores;
   endsequence

   // a store while the stored channel still holds an unread result
   sequence storeOnFull;
      endStores && st_r.eoc[st_r.curCh];
   endsequence

   // a store while data ready is still up from an earlier result
   sequence storeOnReady;
      endStores && st_r.data_ready_flag;
   endsequence

   // a channel disable landing in the cycle of a store
   sequence storeWithDisable;
      endStores && disMask != '0;
   endsequence

   // a channel data read landing in the cycle of a store
   sequence storeWithChRead;
      endStores && chRdHit;
   endsequence

   // a start command that finds at least one enabled channel
   sequence startCmd;
      wrAcc && paddr == OFF_CTRL && pwdata[CTRL_START_BIT] && !st_r.busy && st_r.chEn != '0;
   endsequence

   a_store_sets_ready: assert property (storeEvt |=> st_r.data_ready_flag)
      else $error("data ready missing after store");
   a_ready_clear_src: assert property ($fell(st_r.data_ready_flag) |-> $past(rdLast))
      else $error("data ready cleared without last read");
   a_chread_keeps: assert property (chRdHit && !rdLast && st_r.data_ready_flag |=> st_r.data_ready_flag)
      else $error("channel read cleared data ready");
   a_eoc_read_clr: assert property (rdCh[0] && !(endStores && st_r.curCh == 3'd0)
                                    |=> !st_r.eoc[0])
      else $error("channel read left end flag");
   a_govr_set: assert property (storeOnReady |=> st_r.govr)
      else $error("general overrun not set");
   a_govr_clear: assert property (rdStat && !(endStores && st_r.data_ready_flag) |=> !st_r.govr)
      else $error("general overrun not reset");
   a_ovr_set: assert property (endStores && st_r.eoc[st_r.curCh]
                               |=> st_r.ovr[$past(st_r.curCh)])
      else $error("channel overrun not set");
   a_ovr_clear: assert property (rdStat |=> st_r.ovr == '0 ||
                                 $past(endStores))
      else $error("channel overrun not reset");
   a_sleep_defer: assert property ($rose(st_r.sleepOn) |-> $past(convEnd))
      else $error("sleep entered without conversion end");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held two cycles");

   // ----------------------------------------------------------------------
   // checks on coincident events
   // ----------------------------------------------------------------------
   // the corrected logic must not lose a set when an access lands with it
   a_chread_ready_set: assert property (storeWithChRead |=> st_r.data_ready_flag)
      else $error("channel read suppressed data ready");
   a_disable_ready: assert property (storeWithDisable |=> st_r.data_ready_flag)
      else $error("disable suppressed data ready");
   a_disable_govr: assert property (storeWithDisable ##0 st_r.data_ready_flag |=> st_r.govr)
      else $error("disable suppressed general overrun");
   a_disable_ovr: assert property (storeWithDisable ##0 st_r.eoc[st_r.curCh]
                                   |=> st_r.ovr[$past(st_r.curCh)])
      else $error("disable suppressed channel overrun");
   a_full_store_ovr: assert property (storeOnFull |=> st_r.ovr != '0)
      else $error("overrun missing on full channel");
   a_eoc_set_wins: assert property (storeEvt |=> st_r.eoc[$past(st_r.curCh)])
      else $error("end flag lost to a clear");

   // a channel read touches its own end flag and no other
   a_chread_own: assert property (chRdHit && !rdLast && !endStores
                                  |=> (st_r.eoc | $past(rdCh)) ==
                                      ($past(st_r.eoc) | $past(rdCh)))
      else $error("channel read cleared a foreign end flag");
   a_last_read_eoc: assert property (rdLast && !endStores
                                     |=> !st_r.eoc[$past(st_r.lastCh)])
      else $error("last read left end flag");

   // ----------------------------------------------------------------------
   // checks on data and sequencing
   // ----------------------------------------------------------------------
   a_store_data: assert property (storeEvt |=> st_r.lastData == $past(convResult))
      else $error("last data not stored");
   a_start_busy: assert property (startCmd |=> st_r.busy)
      else $error("start did not begin a scan");
   a_conv_bound: assert property (st_r.busy |-> st_r.convCnt < 5'(CONV_CYCLES))
      else $error("conversion counter overran");
   a_idle_no_end: assert property (!st_r.busy |-> !convEnd)
      else $error("conversion end while idle");
   a_disable_takes: assert property (disMask != '0 |=> (st_r.chEn & $past(disMask)) == '0)
      else $error("channel still enabled after disable");

   // ----------------------------------------------------------------------
   // checks on the bus answer and the wake write
   // ----------------------------------------------------------------------
   // read data must be quiet outside the answer cycle
   a_rdata_quiet: assert property (!pready |-> prdata == ZERO_WORD)
      else $error("read data outside answer cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_sleep_wake: assert property (wrAcc && paddr == OFF_MODE && !pwdata[MODE_SLEEP_BIT]
                                  |=> !st_r.sleepOn)
      else $error("sleep kept after wake write");
endmodule

// *** adc_status_flag_logic_tb_top.sv ***
module adc_status_flag_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_flag_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] RESULT = 10'h2A5;
   localparam logic [31:0]       START  = 32'h0000_0001 << CTRL_START_BIT;
   logic              clk;
   logic              reset_n;
   logic [11:0]       paddr;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [DATA_W-1:0] convResult;
   logic              sleepActive;
   logic [31:0]       rdat;
   logic              rerr;
   int                fails;
   int                n_compared;

   adc_status_flag_logic dut (
      .clk        (clk),
      .reset_n    (reset_n),
      .paddr      (paddr),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .convResult (convResult),
      .sleepActive(sleepActive)
   );

   // 25 ns period
   always #12.5 clk = ~clk;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      if (fails == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         if (pready === 1'h1) begin
            break;
         end
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      if (i == 8) begin
         fails++;
         end_sim();
      end
   endtask

   // fixed wait: two enabled channels at 20 cycles each, plus margin
   task automatic scan();
      apb(1'h1, OFF_CTRL, START);
      repeat (50) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic reset_values();
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("status after reset", rdat, ZERO_WORD);
      check("sleep after reset", 32'(sleepActive), ZERO_WORD);
   endtask

   // second channel ends with ready still up, so overrun must show
   task automatic conv_flags();
      apb(1'h1, OFF_CH_EN, 32'h0000_0005);
      scan();
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("eoc after scan", 32'(rdat[7:0]), 32'h0000_0005);
      check("ready after scan", 32'(rdat[ST_DATA_READY_FLAG_BIT]), 32'h0000_0001);
      check("general overrun", 32'(rdat[ST_GOVR_BIT]), 32'h0000_0001);
      check("busy after scan", 32'(rdat[ST_BUSY_BIT]), ZERO_WORD);
      check("no channel overrun", 32'(rdat[ST_OVR_LSB +: 8]), ZERO_WORD);
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("general overrun reset", 32'(rdat[ST_GOVR_BIT]), ZERO_WORD);
      scan();
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("channel overrun", 32'(rdat[ST_OVR_LSB +: 8]), 32'h0000_0005);
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("channel overrun reset", 32'(rdat[ST_OVR_LSB +: 8]), ZERO_WORD);
   endtask

   task automatic data_reads();
      apb(1'h0, OFF_CH_DATA0, ZERO_WORD);
      check("channel 0 data", 32'(rdat[DATA_W-1:0]), 32'(RESULT));
      check("channel 0 error", 32'(rerr), ZERO_WORD);
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("eoc after channel read", 32'(rdat[7:0]), 32'h0000_0004);
      check("ready kept", 32'(rdat[ST_DATA_READY_FLAG_BIT]), 32'h0000_0001);
      apb(1'h0, OFF_LAST_DATA, ZERO_WORD);
      check("last data", 32'(rdat[DATA_W-1:0]), 32'(RESULT));
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("eoc after last read", 32'(rdat[7:0]), ZERO_WORD);
      check("ready cleared", 32'(rdat[ST_DATA_READY_FLAG_BIT]), ZERO_WORD);
   endtask

   // channel 2 disabled mid scan; its stale end flag is not judged
   task automatic channel_disable();
      apb(1'h1, OFF_CTRL, START);
      apb(1'h1, OFF_CH_DIS, 32'h0000_0004);
      repeat (50) @(posedge clk);
      apb(1'h0, OFF_CH_STAT, ZERO_WORD);
      check("enabled after disable", rdat, 32'h0000_0001);
      apb(1'h0, OFF_STATUS, ZERO_WORD);
      check("busy after disable", 32'(rdat[ST_BUSY_BIT]), ZERO_WORD);
      check("ready after disable", 32'(rdat[ST_DATA_READY_FLAG_BIT]), 32'h0000_0001);
      check("channel 0 end", 32'(rdat[0]), 32'h0000_0001);
   endtask

   // misaligned places and those past the last channel data register answer zero with an error
   task automatic bad_address();
      apb(1'h0, 12'h022, ZERO_WORD);
      check("misaligned error", 32'(rerr), 32'h0000_0001);
      apb(1'h0, 12'h100, ZERO_WORD);
      check("unmapped error", 32'(rerr), 32'h0000_0001);
      check("unmapped data", rdat, ZERO_WORD);
   endtask

   task automatic sleep_deferred();
      apb(1'h1, OFF_MODE, 32'h0000_0001 << MODE_SLEEP_BIT);
      repeat (30) @(posedge clk);
      check("sleep while idle", 32'(sleepActive), ZERO_WORD);
      apb(1'h1, OFF_CTRL, START);
      repeat (10) @(posedge clk);
      check("sleep during scan", 32'(sleepActive), ZERO_WORD);
      repeat (50) @(posedge clk);
      check("sleep after scan", 32'(sleepActive), 32'h0000_0001);
      apb(1'h1, OFF_MODE, ZERO_WORD);
      repeat (3) @(posedge clk);
      check("awake again", 32'(sleepActive), ZERO_WORD);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk        = 1'h0;
      reset_n    = 1'h0;
      paddr      = 12'h000;
      psel       = 1'h0;
      penable    = 1'h0;
      pwrite     = 1'h0;
      pwdata     = ZERO_WORD;
      convResult = RESULT;
      fails      = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      reset_values();
      conv_flags();
      data_reads();
      bad_address();
      sleep_deferred();
      channel_disable();
      end_sim();
   end
endmodule
